/* src/eir_chan_end.sv */
// Channel end: local state buffer, subchannel pool, X_ID reassignment.
// Assumes the disk keeps one frame outstanding until its ACK.
`timescale 1ns/10ps
module eir_chan_end #(
	parameter int NUM_SLOT = eir_pkg::NUM_SLOT,
	parameter int NUM_SUB = eir_pkg::NUM_SUB
) (
	input wire logic clk,
	input wire logic rst_n,
	eir_link_if.chanEnd link,
	input wire logic hostWe,
	input wire logic [$clog2(NUM_SUB)-1:0] hostIdx,
	input wire logic [eir_pkg::DATA_W-1:0] hostWdata,
	output logic [eir_pkg::DATA_W-1:0] hostRdata,
	output logic [NUM_SLOT-1:0] slotBusy,
	output logic [NUM_SUB-1:0] subLocked
);
	localparam int SLOT_W = $clog2(NUM_SLOT);
	localparam int SUB_W = $clog2(NUM_SUB);
	localparam int XW = eir_pkg::XID_W;
	localparam int DW = eir_pkg::DATA_W;

	////////////////////////////////////////////////////////////////////
	eir_pkg::eir_chan_st_e state_q, state_d;
	logic rdy_q;
	logic [eir_pkg::PORT_W-1:0] fSid_q;
	logic [XW-1:0] fOxId_q, fRxId_q;
	logic fInval_q, fAssoc_q, fLast_q;
	logic [eir_pkg::AS_W-1:0] fOoAs_q;
	logic [DW-1:0] fData_q;
	logic ackValid_q, ackInval_q, ackReject_q;
	logic [XW-1:0] ackOxId_q, ackRxId_q;
	logic [NUM_SLOT-1:0] slotValid_q;
	logic [SUB_W-1:0] slotSub_q [NUM_SLOT];
	logic [DW-1:0] slotData_q [NUM_SLOT];
	logic [DW-1:0] subMem_q [NUM_SUB];
	logic [NUM_SUB-1:0] subLock_q;
	logic [DW-1:0] hostRdata_q;

	////////////////////////////////////////////////////////////////////
	wire frameTaken = (state_q == eir_pkg::CH_IDLE) && link.frmValid;
	wire inExec = (state_q == eir_pkg::CH_EXEC);
	// Null OX_ID with a header means reconnection, any sender
	wire isRecon = fAssoc_q && (fOxId_q == eir_pkg::XID_NULL);
	wire [SLOT_W-1:0] hitSlot = fOxId_q[SLOT_W-1:0];
	// Null never falls below NUM_SLOT, so it hits no slot
	wire oxInRange = (fOxId_q < XW'(NUM_SLOT));
	wire oxHit = !isRecon && oxInRange && slotValid_q[hitSlot];
	wire [SUB_W-1:0] subIdx = fOoAs_q[SUB_W-1:0];
	wire subInRange = (fOoAs_q < eir_pkg::AS_W'(NUM_SUB));
	wire freeFound;
	wire [SLOT_W-1:0] freeIdx;
	// A locked subchannel belongs to another exchange: refuse
	wire reconOk = isRecon && freeFound && subInRange && !subLock_q[subIdx];
	wire [DW-1:0] newData = slotData_q[hitSlot] + fData_q;
	wire leaving = fInval_q || fLast_q;
	wire doAlloc = inExec && reconOk;
	wire doData = inExec && oxHit;
	wire doRelease = doData && leaving;
	wire [SUB_W-1:0] relSub = slotSub_q[hitSlot];

	eir_free_slot #(
		.NUM(NUM_SLOT),
		.IDX_W(SLOT_W)
	) u_free (
		.busy(slotValid_q),
		.found(freeFound),
		.idx(freeIdx)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			eir_pkg::CH_IDLE: begin
				if (link.frmValid) begin
					state_d = eir_pkg::CH_EXEC;
				end
			end
			eir_pkg::CH_EXEC: begin
				state_d = eir_pkg::CH_ACK;
			end
			default: begin
				state_d = eir_pkg::CH_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= eir_pkg::CH_IDLE;
			rdy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rdy_q <= (state_d == eir_pkg::CH_IDLE);
		end
	end

	// Frame capture; fields only meaningful once taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fSid_q <= '0;
			fOxId_q <= eir_pkg::XID_NULL;
			fRxId_q <= eir_pkg::XID_NULL;
			fInval_q <= 1'b0;
			fAssoc_q <= 1'b0;
			fLast_q <= 1'b0;
			fOoAs_q <= eir_pkg::AS_NULL;
			fData_q <= eir_pkg::DATA_RST;
		end else if (frameTaken) begin
			fSid_q <= link.frmSid;
			fOxId_q <= link.frmOxId;
			fRxId_q <= link.frmRxId;
			fInval_q <= link.frmInval;
			fAssoc_q <= link.frmAssoc;
			fLast_q <= link.frmLast;
			fOoAs_q <= link.frmOoAs;
			fData_q <= link.frmData;
		end
	end

	// ACK prepared in EXEC, shown for the one ACK cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ackValid_q <= 1'b0;
			ackOxId_q <= eir_pkg::XID_NULL;
			ackRxId_q <= eir_pkg::XID_NULL;
			ackInval_q <= 1'b0;
			ackReject_q <= 1'b0;
		end else if (inExec) begin
			ackValid_q <= 1'b1;
			ackRxId_q <= fRxId_q;
			ackReject_q <= !(reconOk || oxHit);
			if (reconOk) begin
				ackOxId_q <= XW'(freeIdx);
			end else begin
				ackOxId_q <= fOxId_q;
			end
			ackInval_q <= oxHit && fInval_q;
		end else begin
			ackValid_q <= 1'b0;
			ackInval_q <= 1'b0;
			ackReject_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slot bookkeeping
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slotValid_q <= '0;
		end else if (doAlloc) begin
			slotValid_q[freeIdx] <= 1'b1;
		end else if (doRelease) begin
			slotValid_q[hitSlot] <= 1'b0;
		end
	end

	// Buffer contents carry no reset; valid bits guard them
	always_ff @(posedge clk) begin
		if (doAlloc) begin
			slotSub_q[freeIdx] <= subIdx;
			slotData_q[freeIdx] <= subMem_q[subIdx];
		end else if (doData) begin
			slotData_q[hitSlot] <= newData;
		end
	end

	// Host preload loses to a write-back on the same cycle
	always_ff @(posedge clk) begin
		if (doRelease) begin
			subMem_q[relSub] <= newData;
		end else if (hostWe) begin
			subMem_q[hostIdx] <= hostWdata;
		end
		hostRdata_q <= subMem_q[hostIdx];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			subLock_q <= '0;
		end else if (doAlloc) begin
			subLock_q[subIdx] <= 1'b1;
		end else if (doRelease) begin
			subLock_q[relSub] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign link.frmReady = rdy_q;
	assign link.ackValid = ackValid_q;
	assign link.ackOxId = ackOxId_q;
	assign link.ackRxId = ackRxId_q;
	assign link.ackInval = ackInval_q;
	assign link.ackReject = ackReject_q;
	assign hostRdata = hostRdata_q;
	assign slotBusy = slotValid_q;
	assign subLocked = subLock_q;
endmodule : eir_chan_end

/* src/eir_disk_end.sv */
// Disk end: sends data, disconnect, reconnect and termination frames.
// Assumes the user issues commands only while cmdReady is high.
`timescale 1ns/10ps
module eir_disk_end (
	input wire logic clk,
	input wire logic rst_n,
	eir_link_if.diskEnd link,
	input wire logic cmdValid,
	input wire eir_pkg::eir_op_e cmdOp,
	input wire logic [eir_pkg::PORT_W-1:0] cmdSid,
	input wire logic [eir_pkg::PORT_W-1:0] cmdDid,
	input wire logic [eir_pkg::AS_W-1:0] cmdOoAs,
	input wire logic [eir_pkg::AS_W-1:0] cmdRoAs,
	input wire logic [eir_pkg::DATA_W-1:0] cmdData,
	input wire logic dedConn,
	input wire logic onlyExch,
	output logic cmdReady,
	output logic doneValid,
	output logic doneReject,
	output logic endConnReq,
	output logic [eir_pkg::XID_W-1:0] curOxId,
	output logic [eir_pkg::XID_W-1:0] curRxId
);
	localparam int XW = eir_pkg::XID_W;

	eir_pkg::eir_disk_st_e state_q, state_d;
	eir_pkg::eir_op_e op_q;
	logic rdy_q, done_q, rej_q, endConn_q;
	logic [XW-1:0] ox_q, rx_q, rxNext_q;
	logic [eir_pkg::PORT_W-1:0] sid_q, did_q;
	logic [eir_pkg::AS_W-1:0] ooAs_q, roAs_q;
	logic [eir_pkg::DATA_W-1:0] data_q;

	wire take = (state_q == eir_pkg::DK_IDLE) && cmdValid;
	wire acked = (state_q == eir_pkg::DK_WAIT) && link.ackValid;
	wire isRecon = (op_q == eir_pkg::OP_RECON);
	wire leave = (op_q == eir_pkg::OP_DISC) || (op_q == eir_pkg::OP_TERM);

	always_comb begin
		state_d = state_q;
		case (state_q)
			eir_pkg::DK_IDLE: begin
				if (cmdValid) begin
					state_d = eir_pkg::DK_SEND;
				end
			end
			eir_pkg::DK_SEND: begin
				if (link.frmReady) begin
					state_d = eir_pkg::DK_WAIT;
				end
			end
			default: begin
				// Nothing more goes out until the ACK
				if (link.ackValid) begin
					state_d = eir_pkg::DK_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= eir_pkg::DK_IDLE;
			rdy_q <= 1'b0;
			done_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rdy_q <= (state_d == eir_pkg::DK_IDLE);
			done_q <= acked;
			rej_q <= acked && link.ackReject;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= eir_pkg::OP_DATA;
			sid_q <= '0;
			did_q <= '0;
			ooAs_q <= eir_pkg::AS_NULL;
			roAs_q <= eir_pkg::AS_NULL;
			data_q <= eir_pkg::DATA_RST;
		end else if (take) begin
			op_q <= cmdOp;
			sid_q <= cmdSid;
			did_q <= cmdDid;
			ooAs_q <= cmdOoAs;
			roAs_q <= cmdRoAs;
			data_q <= cmdData;
		end
	end

	// Identifier tracking; a refused reconnect still takes a fresh RX_ID, keeps OX_ID
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ox_q <= eir_pkg::XID_NULL;
			rx_q <= eir_pkg::XID_NULL;
			rxNext_q <= eir_pkg::RXID_FIRST;
		end else if (take && cmdOp == eir_pkg::OP_RECON) begin
			rx_q <= rxNext_q;
			rxNext_q <= rxNext_q + 8'h01;
		end else if (acked && !link.ackReject) begin
			if (isRecon) begin
				ox_q <= link.ackOxId;
			end else if (leave) begin
				ox_q <= eir_pkg::XID_NULL;
				rx_q <= eir_pkg::XID_NULL;
			end
		end
	end

	// Sole exchange on a dedicated connection: ask for E_C end
	// A refused leave disconnects nothing, so no end then
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			endConn_q <= 1'b0;
		end else begin
			endConn_q <= acked && !link.ackReject && leave
				&& dedConn && onlyExch;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign link.frmValid = (state_q == eir_pkg::DK_SEND);
	assign link.frmSid = sid_q;
	assign link.frmDid = did_q;
	assign link.frmOxId = isRecon ? eir_pkg::XID_NULL : ox_q;
	assign link.frmRxId = rx_q;
	assign link.frmNewXid = isRecon;
	assign link.frmAssoc = isRecon;
	assign link.frmInval = (op_q == eir_pkg::OP_DISC);
	assign link.frmLast = (op_q == eir_pkg::OP_TERM);
	assign link.frmOoAs = isRecon ? ooAs_q : eir_pkg::AS_NULL;
	assign link.frmRoAs = isRecon ? roAs_q : eir_pkg::AS_NULL;
	assign link.frmData = data_q;
	assign cmdReady = rdy_q;
	assign doneValid = done_q;
	assign doneReject = rej_q;
	assign endConnReq = endConn_q;
	assign curOxId = ox_q;
	assign curRxId = rx_q;
endmodule : eir_disk_end

/* src/eir_free_slot.sv */
// Lowest-index free slot finder for the local state buffer.
// Assumes busy vector comes from registers; purely combinational.
`timescale 1ns/10ps
module eir_free_slot #(
	parameter int NUM = 4,
	parameter int IDX_W = 2
) (
	input wire logic [NUM-1:0] busy,
	output logic found,
	output logic [IDX_W-1:0] idx
);
	logic [NUM:0] seen;
	logic [IDX_W-1:0] pick [NUM:0];

	assign seen[0] = 1'b0;
	assign pick[0] = '0;

	// Ripple keeps the lowest free index
	for (genvar i = 0; i < NUM; i++) begin : g_scan
		assign seen[i+1] = seen[i] | ~busy[i];
		assign pick[i+1] = (!seen[i] && !busy[i]) ? IDX_W'(i) : pick[i];
	end

	assign found = seen[NUM];
	assign idx = pick[NUM];
endmodule : eir_free_slot

/* src/eir_link_if.sv */
// Frame-level link between the disk end and the channel end.
// Assumes both ends share clk; one frame and one ACK at a time.
`timescale 1ns/10ps
interface eir_link_if;
	logic frmValid;
	logic frmReady;
	logic [eir_pkg::PORT_W-1:0] frmDid;
	logic [eir_pkg::PORT_W-1:0] frmSid;
	logic [eir_pkg::XID_W-1:0] frmOxId;
	logic [eir_pkg::XID_W-1:0] frmRxId;
	logic frmInval;
	logic frmNewXid;
	logic frmAssoc;
	logic frmLast;
	logic [eir_pkg::AS_W-1:0] frmOoAs;
	logic [eir_pkg::AS_W-1:0] frmRoAs;
	logic [eir_pkg::DATA_W-1:0] frmData;
	logic ackValid;
	logic [eir_pkg::XID_W-1:0] ackOxId;
	logic [eir_pkg::XID_W-1:0] ackRxId;
	logic ackInval;
	logic ackReject;

	modport chanEnd (
		input frmValid, frmDid, frmSid, frmOxId, frmRxId, frmInval,
		input frmNewXid, frmAssoc, frmLast, frmOoAs, frmRoAs, frmData,
		output frmReady, ackValid, ackOxId, ackRxId, ackInval, ackReject
	);
	modport diskEnd (
		output frmValid, frmDid, frmSid, frmOxId, frmRxId, frmInval,
		output frmNewXid, frmAssoc, frmLast, frmOoAs, frmRoAs, frmData,
		input frmReady, ackValid, ackOxId, ackRxId, ackInval, ackReject
	);
endinterface : eir_link_if

/* src/eir_pkg.sv */
// Shared constants and types for exchange identifier reassignment.
// Assumes one clock domain and a frame-level parallel link.
// Functional notes
// - Disk flags Invalidate X_ID when leaving; code sets frmInval on disconnect only, not on termination
// - Disk ends sole dedicated connection on leave
// - Channel ACK to last frame invalidates X_ID; code sets ackInval on disconnect only, not on termination
// - Disconnect writes slot back, frees slot
// - Disk picks the port pair for reconnection
// - Reconnect frame carries null OX_ID
// - Reconnect frame: fresh RX_ID, new-ID flag
// - Disk returns original originator associator
// - Responder associator is disk's own choice
// - Disk waits for reconnect ACK first
// - Later frames carry no association header
// - Any reachable channel accepts reconnection
// - Null OX_ID routes by association header
// - Reconnect allocates a free buffer slot
// - Originator associator selects subchannel
// - Lock subchannel, load it into slot
// - New OX_ID from slot, sent in ACK
// - Later frames routed by OX_ID only
// - Termination writes slot back, frees slot
package eir_pkg;
	localparam int XID_W = 8;
	localparam int AS_W = 8;
	localparam int DATA_W = 16;
	localparam int PORT_W = 8;
	localparam int NUM_SLOT = 4;
	localparam int NUM_SUB = 16;
	localparam logic [XID_W-1:0] XID_NULL = 8'hFF;
	localparam logic [AS_W-1:0] AS_NULL = 8'hFF;
	localparam logic [XID_W-1:0] RXID_FIRST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		OP_RECON = 2'b00,
		OP_DATA = 2'b01,
		OP_DISC = 2'b10,
		OP_TERM = 2'b11
	} eir_op_e;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_EXEC = 2'b01,
		CH_ACK = 2'b11
	} eir_chan_st_e;

	typedef enum logic [1:0] {
		DK_IDLE = 2'b00,
		DK_SEND = 2'b01,
		DK_WAIT = 2'b11
	} eir_disk_st_e;
endpackage : eir_pkg

/* tb/eir_link_monitor.sv */
// Concurrent checks on the frame link between the two ends.
// Assumes one clock; instantiated in tb beside the link interface.
`timescale 1ns/10ps
module eir_link_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frmValid,
	input wire logic frmReady,
	input wire logic [eir_pkg::XID_W-1:0] frmOxId,
	input wire logic [eir_pkg::XID_W-1:0] frmRxId,
	input wire logic frmInval,
	input wire logic frmNewXid,
	input wire logic frmAssoc,
	input wire logic ackValid,
	input wire logic [eir_pkg::XID_W-1:0] ackOxId,
	input wire logic [eir_pkg::XID_W-1:0] ackRxId,
	input wire logic ackInval,
	input wire logic ackReject
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = frmValid && frmReady;
	sequence s_recon;
		take && frmNewXid;
	endsequence
	sequence s_ack_ok;
		ackValid && !ackReject;
	endsequence
	////////////////////////////////////////////////////////////////////////
	chk_ack_latency: assert property (
		take |-> !ackValid ##1 !ackValid ##1 ackValid)
		else $error("ack not two cycles after frame");
	chk_one_outstanding: assert property (
		take |=> !frmReady [*2])
		else $error("channel ready while frame outstanding");
	// Channel is always ready when idle, so watch the wait instead
	chk_frame_hold: assert property (
		take |=> (!frmValid && $stable(frmOxId)) [*2])
		else $error("disk sent a frame before the ack");
	chk_disc_inval: assert property (
		take && frmInval |-> ##2 (ackReject || ackInval))
		else $error("disconnect ack lacks invalidate");
	chk_inval_cause: assert property (
		ackValid && ackInval |-> $past(frmInval, 2))
		else $error("invalidate ack without disconnect frame");
	chk_recon_ids: assert property (
		s_recon |-> frmOxId == eir_pkg::XID_NULL && frmAssoc)
		else $error("reconnect frame ids wrong");
	chk_recon_newid: assert property (
		s_recon ##2 s_ack_ok |-> ackOxId < eir_pkg::NUM_SLOT)
		else $error("reconnect ack id not a slot");
	chk_rxid_echo: assert property (
		take |-> ##2 ackRxId == $past(frmRxId, 2))
		else $error("ack rx id differs");
	chk_no_header: assert property (
		take && !frmNewXid |-> !frmAssoc)
		else $error("header on later frame");
	chk_null_route: assert property (
		take && !frmNewXid && frmOxId == eir_pkg::XID_NULL
		|-> ##2 ackReject)
		else $error("null id frame was routed");
endmodule : eir_link_monitor

/* tb/tb.sv */
// Bench joining disk and channel ends over the link, with a model.
// Assumes package and interface compiled first.
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmdValid = 1'b0;
	eir_pkg::eir_op_e cmdOp = eir_pkg::OP_DATA;
	logic [7:0] cmdSid = 8'h00, cmdDid = 8'h00, cmdOoAs = 8'h00;
	logic [7:0] cmdRoAs = 8'h00, curOxId, curRxId;
	logic [15:0] cmdData = 16'h0000, hostWdata = 16'h0000, hostRdata;
	logic dedConn = 1'b0, onlyExch = 1'b0, hostWe = 1'b0;
	logic [3:0] hostIdx = 4'h0, slotBusy;
	logic [15:0] subLocked;
	logic cmdReady, doneValid, doneReject, endConnReq;
	int num_errors = 0, checks = 0, cycles = 0, ecCnt = 0;
	int seed, curOx, curRx, rxNext, r, op;
	int mem[16], lk[16], sVal[4], sSub[4], sDat[4];
	int dOp[10] = '{1, 0, 0, 0, 0, 0, 0, 0, 1, 3};
	int dOo[10] = '{0, 3, 3, 5, 6, 7, 8, 32, 0, 0};
	eir_link_if link();
	eir_chan_end i_eir_chan_end (.clk(clk), .rst_n(rst_n), .link(link),
		.hostWe(hostWe), .hostIdx(hostIdx), .hostWdata(hostWdata),
		.hostRdata(hostRdata), .slotBusy(slotBusy), .subLocked(subLocked));
	eir_disk_end i_eir_disk_end (.clk(clk), .rst_n(rst_n), .link(link),
		.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSid(cmdSid), .cmdDid(cmdDid),
		.cmdOoAs(cmdOoAs), .cmdRoAs(cmdRoAs), .cmdData(cmdData),
		.dedConn(dedConn), .onlyExch(onlyExch), .cmdReady(cmdReady),
		.doneValid(doneValid), .doneReject(doneReject),
		.endConnReq(endConnReq), .curOxId(curOxId), .curRxId(curRxId));
	eir_link_monitor i_eir_link_monitor (.clk(clk), .rst_n(rst_n),
		.frmValid(link.frmValid), .frmReady(link.frmReady),
		.frmOxId(link.frmOxId), .frmRxId(link.frmRxId),
		.frmInval(link.frmInval), .frmNewXid(link.frmNewXid),
		.frmAssoc(link.frmAssoc), .ackValid(link.ackValid),
		.ackOxId(link.ackOxId), .ackRxId(link.ackRxId),
		.ackInval(link.ackInval), .ackReject(link.ackReject));
	////////////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;
	always @(negedge clk) if (endConnReq === 1'b1) ecCnt++;
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (num_errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : cmp_val
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		cmp_val(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask : cmp_bit
	////////////////////////////////////////////////////////////////////////
	task automatic check_state();
		logic [3:0] eb;
		logic [15:0] el;
		for (int i = 0; i < 4; i++) eb[i] = sVal[i][0];
		for (int i = 0; i < 16; i++) el[i] = lk[i][0];
		cmp_val("slotBusy", eb, slotBusy);
		cmp_val("subLocked", el, subLocked);
		cmp_val("curOxId", curOx, curOxId);
		cmp_val("curRxId", curRx, curRxId);
	endtask : check_state
	task automatic check_mem();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk) hostIdx <= i[3:0];
			@(posedge clk);
			@(negedge clk) cmp_val("hostRdata", mem[i], hostRdata);
		end
	endtask : check_mem
	task automatic do_cmd(input int op, input int oo, input int dat, input int ded);
		int n, s, sb;
		bit rej, ec;
		rej = 1;
		ec = 0;
		s = -1;
		// Model of both ends; reconnect payload is not added
		// Disk takes a fresh RX_ID even for a refused reconnect
		if (op == 0) begin
			curRx = rxNext;
			rxNext = (rxNext + 1) & 255;
			for (int i = 3; i >= 0; i--) if (sVal[i] == 0) s = i;
			if (oo < 16 && s >= 0 && lk[oo] == 0) begin
				rej = 0;
				sVal[s] = 1;
				sSub[s] = oo;
				sDat[s] = mem[oo];
				lk[oo] = 1;
				curOx = s;
			end
		end else if (curOx < 4 && sVal[curOx] == 1) begin
			rej = 0;
			sDat[curOx] = (sDat[curOx] + dat) & 32'h0000_ffff;
			if (op >= 2) begin
				sb = sSub[curOx];
				mem[sb] = sDat[curOx];
				lk[sb] = 0;
				sVal[curOx] = 0;
				curOx = 255;
				curRx = 255;
				ec = (ded == 3);
			end
		end
		r = $random(seed);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdOp <= eir_pkg::eir_op_e'(op[1:0]);
		cmdOoAs <= oo[7:0];
		cmdRoAs <= r[7:0];
		cmdSid <= r[15:8];
		cmdDid <= r[23:16];
		cmdData <= dat[15:0];
		dedConn <= ded[0];
		onlyExch <= ded[1];
		n = 0;
		@(posedge clk);
		while (cmdReady !== 1'b1 && n < 40) begin
			n++;
			@(posedge clk);
		end
		cmdValid <= 1'b0;
		ecCnt = 0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (doneValid !== 1'b1 && n < 40);
		cmp_bit("doneReject", rej, doneReject);
		check_state();
		@(negedge clk) cmp_val("endConnReq", ec, ecCnt);
	endtask : do_cmd
	task automatic do_reset();
		@(posedge clk) rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 16; i++) lk[i] = 0;
		for (int i = 0; i < 4; i++) sVal[i] = 0;
		curOx = 255;
		curRx = 255;
		rxNext = 0;
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hd19b_18f6;
		do_reset();
		for (int i = 0; i < 16; i++) begin
			mem[i] = $random(seed) & 32'h0000_ffff;
			@(posedge clk);
			hostWe <= 1'b1;
			hostIdx <= i[3:0];
			hostWdata <= mem[i][15:0];
		end
		@(posedge clk) hostWe <= 1'b0;
		check_mem();
		// Stray data refused, fill every slot with a lock refusal, refuse when full, then data and terminate
		for (int k = 0; k < 10; k++) do_cmd(dOp[k], dOo[k], k * 7, 0);
		check_mem();
		do_reset();
		check_state();
		for (int k = 0; k < 200; k++) begin
			r = $random(seed);
			if (curOx == 255) op = (r[3:0] == 4'h0) ? 1 : 0;
			else op = 1 + ((r >> 4) & 3) % 3;
			do_cmd(op, ((r >> 8) & 255) % 18,
				(op == 0) ? 0 : (r >> 16) & 32'h0000_ffff, (r >> 6) & 3);
		end
		check_mem();
		stop_test();
	end
endmodule : tb
